// ===== src/line_test_pattern_gen_check.sv
// Line test pattern generator and checkers for one framer, with an APB register file.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pattern_map.svh"

module line_test_pattern_gen_check
	import pattern_pkg::*;
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Line side.
	input wire line_in_t line_in,
	output logic tx_line
);

	// ----------------------------------------
	// Pattern functions
	// ----------------------------------------

	// Bit shifted into the pattern register for a given code.
	function automatic logic pat_fb(input logic [3:0] code, input logic [22:0] s);
		case (code)
			`PAT_ALL1: pat_fb = 1'b1;
			`PAT_ALT: pat_fb = ~s[0];
			`PAT_P5: pat_fb = s[4] ^ s[2];
			`PAT_P6: pat_fb = s[5] ^ s[4];
			`PAT_P9, `PAT_P9R: pat_fb = s[8] ^ s[4];
			`PAT_P11, `PAT_P11R: pat_fb = s[10] ^ s[8];
			`PAT_P15: pat_fb = s[14] ^ s[13];
			`PAT_QUASI_RANDOM_SIGNAL, `PAT_P20A, `PAT_P20B: pat_fb = s[19] ^ s[16];
			`PAT_P23: pat_fb = s[22] ^ s[17];
			default: pat_fb = 1'b1;
		endcase
	endfunction : pat_fb

	// Line bit produced from the shifted bit; QUASI_RANDOM_SIGNAL forces a one over long zero runs.
	function automatic logic pat_out(input logic [3:0] code, input logic [22:0] s, input logic fb);
		case (code)
			`PAT_QUASI_RANDOM_SIGNAL: pat_out = fb | (s[18:5] == 14'h0000);
			`PAT_P9R, `PAT_P11R: pat_out = ~fb;
			default: pat_out = fb;
		endcase
	endfunction : pat_out

	// ----------------------------------------
	// Frame position
	// ----------------------------------------
	logic [8:0] pos_ff;
	logic [8:0] cur_pos;
	logic overhead;
	logic bit_en;
	logic [2:0] slot_bit;

	// The frame counter wraps at 193 or 256 bits; framing is bit 0 in T1 and slot 0 in E1.
	// The frame strobe marks the current bit as position 0, so the next bit is position 1.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_ff <= 9'h000;
		end else if (bit_en) begin
			if (line_in.e1_mode) begin
				pos_ff <= (cur_pos == `E1_FRAME_BITS - 9'h001) ? 9'h000 : cur_pos + 9'h001;
			end else begin
				pos_ff <= (cur_pos == {1'b0, `T1_FRAME_BITS} - 9'h001) ? 9'h000 : cur_pos + 9'h001;
			end
		end else if (line_in.frame_start) begin
			pos_ff <= 9'h000;
		end
	end

	assign bit_en = line_in.bit_en;
	assign cur_pos = line_in.frame_start ? 9'h000 : pos_ff;
	assign overhead = line_in.e1_mode ? (cur_pos < `E1_OVH_BITS) : (cur_pos == 9'h000);
	assign slot_bit = line_in.e1_mode ? cur_pos[2:0] : 3'(cur_pos - 9'h001);

	// ----------------------------------------
	// Registers and APB slave
	// ----------------------------------------
	logic [7:0] tx_basic_pattern_ctrl_ff;
	logic [7:0] tx_select_pattern_ctrl_ff;
	logic [7:0] rx_select_pattern_ctrl_ff;
	logic [7:0] idle_code_reg_ff;
	logic [15:0] viol_count_ff;
	logic det_err_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [7:0] status_word;
	logic wr_en;
	logic rd_status;
	logic det_en;
	lock_state_t st_ff [3];

	assign wr_en = apb_req.psel & apb_req.penable & pready_ff & apb_req.pwrite;
	assign rd_status = apb_req.psel & apb_req.penable & pready_ff & ~apb_req.pwrite
		& (apb_req.paddr == `OFF_RX_STATUS);
	assign det_en = rx_select_pattern_ctrl_ff[`DET_ENABLE];
	assign status_word = {st_ff[1] == LOCKED, st_ff[0] == LOCKED, det_err_ff, st_ff[2] == LOCKED, 4'h0};

	// Control registers take their value at the access edge; the pattern fields are steered below.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_basic_pattern_ctrl_ff <= `CTRL_RESET;
			tx_select_pattern_ctrl_ff <= `CTRL_RESET;
			rx_select_pattern_ctrl_ff <= `CTRL_RESET;
			idle_code_reg_ff <= `IDLE_RESET;
		end else if (wr_en) begin
			if (apb_req.paddr == `OFF_TX_BASIC) begin
				tx_basic_pattern_ctrl_ff <= apb_req.pwdata[7:0];
			end else if (apb_req.paddr == `OFF_TX_SELECT) begin
				tx_select_pattern_ctrl_ff <= apb_req.pwdata[7:0];
			end else if (apb_req.paddr == `OFF_RX_SELECT) begin
				rx_select_pattern_ctrl_ff <= apb_req.pwdata[7:0];
			end else if (apb_req.paddr == `OFF_IDLE_CODE) begin
				idle_code_reg_ff <= apb_req.pwdata[7:0];
			end
		end
	end

	// Zero-wait answer: pready rises for the access cycle, read data is latched with it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else if (apb_req.psel && !apb_req.penable && !pready_ff) begin
			pready_ff <= 1'b1;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			if (apb_req.paddr == `OFF_TX_BASIC) begin
				prdata_ff[7:0] <= tx_basic_pattern_ctrl_ff;
			end else if (apb_req.paddr == `OFF_TX_SELECT) begin
				prdata_ff[7:0] <= tx_select_pattern_ctrl_ff;
			end else if (apb_req.paddr == `OFF_RX_STATUS) begin
				prdata_ff[7:0] <= status_word;
				pslverr_ff <= apb_req.pwrite;
			end else if (apb_req.paddr == `OFF_RX_SELECT) begin
				prdata_ff[7:0] <= rx_select_pattern_ctrl_ff;
			end else if (apb_req.paddr == `OFF_VIOL_HI) begin
				prdata_ff[7:0] <= viol_count_ff[15:8];
			end else if (apb_req.paddr == `OFF_VIOL_LO) begin
				prdata_ff[7:0] <= viol_count_ff[7:0];
			end else if (apb_req.paddr == `OFF_IDLE_CODE) begin
				prdata_ff[7:0] <= idle_code_reg_ff;
			end else begin
				pslverr_ff <= 1'b1;
			end
		end else begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	// ----------------------------------------
	// Transmit generator
	// ----------------------------------------
	logic [22:0] tx_lfsr_ff;
	logic tx_line_ff;
	logic ins_prev_ff;
	logic ins_pend_ff;
	logic [3:0] tx_code;
	logic tx_fb;
	logic tx_pat;
	logic sel_active;

	// Basic QUASI_RANDOM_SIGNAL and 2^15-1 reuse the selectable generator's shift register.
	assign tx_code = tx_basic_pattern_ctrl_ff[`BASIC_QUASI_RANDOM_SIGNAL] ? `PAT_QUASI_RANDOM_SIGNAL
		: tx_basic_pattern_ctrl_ff[`BASIC_P15] ? `PAT_P15 : tx_select_pattern_ctrl_ff[7:4];
	assign tx_fb = pat_fb(tx_code, tx_lfsr_ff);
	assign tx_pat = pat_out(tx_code, tx_lfsr_ff, tx_fb);
	assign sel_active = (tx_basic_pattern_ctrl_ff == `CTRL_RESET) && (tx_select_pattern_ctrl_ff[7:4] <= `PAT_ALT);

	// The register advances on every bit except the overhead bits of framed patterns; all-zero lockup is reseeded.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_lfsr_ff <= 23'h00_0001;
		end else if (tx_lfsr_ff == 23'h00_0000) begin
			tx_lfsr_ff <= 23'h00_0001;
		end else if (bit_en && !(overhead && (tx_basic_pattern_ctrl_ff[`BASIC_QUASI_RANDOM_SIGNAL]
				|| tx_basic_pattern_ctrl_ff[`BASIC_P15] || tx_select_pattern_ctrl_ff[`SEL_FRAMED]))) begin
			tx_lfsr_ff <= {tx_lfsr_ff[21:0], tx_fb};
		end
	end

	// A 0-to-1 step of the insert bit arms one inverted bit; the arm is set before it is spent.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ins_prev_ff <= 1'b0;
			ins_pend_ff <= 1'b0;
		end else begin
			ins_prev_ff <= tx_select_pattern_ctrl_ff[`SEL_ERR_INS];
			if (sel_active && tx_select_pattern_ctrl_ff[`SEL_ERR_INS] && !ins_prev_ff) begin
				ins_pend_ff <= 1'b1;
			end else if (bit_en && !(overhead && tx_select_pattern_ctrl_ff[`SEL_FRAMED])) begin
				ins_pend_ff <= 1'b0;
			end
		end
	end

	// Line bit selection, highest priority first; framed patterns pass framing, link and CRC bits.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_line_ff <= 1'b1;
		end else if (bit_en) begin
			if (tx_basic_pattern_ctrl_ff[`BASIC_ONES]) begin
				tx_line_ff <= 1'b1;
			end else if (tx_basic_pattern_ctrl_ff[`BASIC_ALT]) begin
				tx_line_ff <= ~tx_line_ff;
			end else if (tx_basic_pattern_ctrl_ff[`BASIC_QUASI_RANDOM_SIGNAL] || tx_basic_pattern_ctrl_ff[`BASIC_P15]) begin
				tx_line_ff <= overhead ? line_in.sys_data : tx_pat;
			end else if (tx_basic_pattern_ctrl_ff[`BASIC_IDLE]) begin
				tx_line_ff <= overhead ? line_in.sys_data : idle_code_reg_ff[3'h7 - slot_bit];
			end else if (sel_active) begin
				if (overhead && tx_select_pattern_ctrl_ff[`SEL_FRAMED]) begin
					tx_line_ff <= line_in.sys_data;
				end else begin
					tx_line_ff <= tx_pat ^ ins_pend_ff;
				end
			end else begin
				tx_line_ff <= line_in.sys_data;
			end
		end
	end

	assign tx_line = tx_line_ff;

	// ----------------------------------------
	// Receive checkers: 0 fixed 2^15-1, 1 fixed QUASI_RANDOM_SIGNAL, 2 selectable
	// ----------------------------------------
	logic chk_err [3];

	for (genvar k = 0; k < 3; k++) begin : g_chk
		logic [22:0] lfsr_ff;
		logic [8:0] run_ff;
		logic [5:0] ferr_ff;
		logic [3:0] code;
		logic enable;
		logic framed;
		logic step;
		logic fb;
		logic match;

		assign code = (k == 0) ? `PAT_P15 : (k == 1) ? `PAT_QUASI_RANDOM_SIGNAL : rx_select_pattern_ctrl_ff[7:4];
		assign enable = (k < 2) || det_en;
		assign framed = (k < 2) || rx_select_pattern_ctrl_ff[`DET_FRAMED];
		assign step = enable && bit_en && !(framed && overhead);
		assign fb = pat_fb(code, lfsr_ff);
		assign match = pat_out(code, lfsr_ff, fb) == line_in.rx_data;
		assign chk_err[k] = step && (st_ff[k] == LOCKED) && !match;

		// Searching reloads from the line so the register self-aligns; locked it runs free.
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				lfsr_ff <= 23'h00_0001;
			end else if (step) begin
				if (st_ff[k] == LOCKED) begin
					lfsr_ff <= {lfsr_ff[21:0], fb};
				end else begin
					lfsr_ff <= {lfsr_ff[21:0], line_in.rx_data ^ (code == `PAT_P9R || code == `PAT_P11R)};
				end
			end
		end

		// Lock needs 256 matches in a row; the fixed monitors drop it beyond 32 errors in a frame.
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				st_ff[k] <= SEARCH;
				run_ff <= 9'h000;
				ferr_ff <= 6'h00;
			end else if (!enable) begin
				st_ff[k] <= SEARCH;
				run_ff <= 9'h000;
				ferr_ff <= 6'h00;
			end else begin
				case (st_ff[k])
					SEARCH: begin
						if (step) begin
							run_ff <= match ? run_ff + 9'h001 : 9'h000;
							if (match && run_ff == `LOCK_BITS - 9'h001) begin
								st_ff[k] <= LOCKED;
							end
						end
						ferr_ff <= 6'h00;
					end
					LOCKED: begin
						run_ff <= 9'h000;
						if (line_in.frame_start) begin
							ferr_ff <= 6'h00;
						end else if (chk_err[k] && k < 2) begin
							if (ferr_ff == `MAX_FRAME_ERRS) begin
								st_ff[k] <= SEARCH;
								ferr_ff <= 6'h00;
							end else begin
								ferr_ff <= ferr_ff + 6'h01;
							end
						end
					end
					default: st_ff[k] <= SEARCH;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Error flag and shared violation counter
	// ----------------------------------------

	// The error flag clears on a status read, but an error in that cycle keeps it set.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			det_err_ff <= 1'b0;
		end else if (det_en && chk_err[2]) begin
			det_err_ff <= 1'b1;
		end else if (rd_status) begin
			det_err_ff <= 1'b0;
		end
	end

	// In test mode the counter counts pattern errors only; it saturates and clears on any write to it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			viol_count_ff <= 16'h0000;
		end else if (wr_en && (apb_req.paddr == `OFF_VIOL_HI || apb_req.paddr == `OFF_VIOL_LO)) begin
			viol_count_ff <= 16'h0000;
		end else if ((det_en ? chk_err[2] : line_in.bipolar_violation) && viol_count_ff != 16'hFFFF) begin
			viol_count_ff <= viol_count_ff + 16'h0001;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	ones_out_a: assert property (bit_en && tx_basic_pattern_ctrl_ff[`BASIC_ONES] |=> tx_line_ff)
		else $error("all ones pattern not sent");
	alt_out_a: assert property (bit_en && tx_basic_pattern_ctrl_ff[1:0] == 2'b10 |=> tx_line_ff != $past(tx_line_ff))
		else $error("alternating pattern did not toggle");
	framed_pass_a: assert property (bit_en && overhead && tx_basic_pattern_ctrl_ff[1:0] == 2'b00
		&& tx_basic_pattern_ctrl_ff[`BASIC_QUASI_RANDOM_SIGNAL] |=> tx_line_ff == $past(line_in.sys_data))
		else $error("framing bit not kept under quasi random pattern");
	lock_run_a: assert property ($rose(st_ff[0] == LOCKED) |-> $past(g_chk[0].run_ff) == `LOCK_BITS - 9'h001)
		else $error("monitor locked before a full error free run");
	unlock_errs_a: assert property ($fell(st_ff[0] == LOCKED) |-> $past(g_chk[0].ferr_ff) == `MAX_FRAME_ERRS)
		else $error("monitor lost lock at the wrong error count");
	det_hold_a: assert property (st_ff[2] == LOCKED && det_en |=> st_ff[2] == LOCKED || !det_en)
		else $error("detector dropped lock while enabled");
	err_count_a: assert property (det_en && chk_err[2] && viol_count_ff != 16'hFFFF && !wr_en
		|=> viol_count_ff == $past(viol_count_ff) + 16'h0001 ##1 1'b1)
		else $error("pattern error not counted");
	err_flag_a: assert property (det_en && chk_err[2] |=> det_err_ff && status_word[`ST_DET_ERR])
		else $error("pattern error flag not set");
	err_insert_a: assert property (sel_active && $rose(tx_select_pattern_ctrl_ff[`SEL_ERR_INS]) |=> ins_pend_ff)
		else $error("error insertion not armed");

	p15_lock_c: cover property ($rose(st_ff[0] == LOCKED));
	quasi_random_signal_lock_c: cover property ($rose(st_ff[1] == LOCKED));
	det_err_c: cover property (st_ff[2] == LOCKED ##[1:300] chk_err[2]);
	insert_c: cover property ($fell(ins_pend_ff));

endmodule : line_test_pattern_gen_check
`default_nettype wire

// ===== src/pattern_map.svh
// Register offsets, field positions, pattern codes and counts of the line test pattern block.
`ifndef PATTERN_MAP_SVH
`define PATTERN_MAP_SVH

// ----------------------------------------
// Register byte offsets and reset values
// ----------------------------------------
`define OFF_TX_BASIC 12'h000
`define OFF_TX_SELECT 12'h004
`define OFF_RX_STATUS 12'h008
`define OFF_RX_SELECT 12'h00C
`define OFF_VIOL_HI 12'h010
`define OFF_VIOL_LO 12'h014
`define OFF_IDLE_CODE 12'h018
`define CTRL_RESET 8'h00
`define IDLE_RESET 8'h7F

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BASIC_ONES 0
`define BASIC_ALT 1
`define BASIC_P15 2
`define BASIC_QUASI_RANDOM_SIGNAL 3
`define BASIC_IDLE 6
`define SEL_ERR_INS 1
`define SEL_FRAMED 3
`define DET_ENABLE 2
`define DET_FRAMED 3
`define ST_DET_LOCK 4
`define ST_DET_ERR 5
`define ST_P15_LOCK 6
`define ST_QUASI_RANDOM_SIGNAL_LOCK 7

// ----------------------------------------
// Pattern select codes (bits 7..4)
// ----------------------------------------
`define PAT_ALL1 4'h0
`define PAT_QUASI_RANDOM_SIGNAL 4'h1
`define PAT_P5 4'h2
`define PAT_P6 4'h3
`define PAT_P9 4'h4
`define PAT_P9R 4'h5
`define PAT_P11 4'h6
`define PAT_P11R 4'h7
`define PAT_P15 4'h8
`define PAT_P20A 4'h9
`define PAT_P20B 4'hA
`define PAT_P23 4'hB
`define PAT_ALT 4'hC

// ----------------------------------------
// Counts
// ----------------------------------------
`define LOCK_BITS 9'h100
`define MAX_FRAME_ERRS 6'h20
`define T1_FRAME_BITS 8'hC1
`define E1_FRAME_BITS 9'h100
`define E1_OVH_BITS 9'h008

`endif

// ===== src/pattern_pkg.sv
// Types shared by the line test pattern block.
package pattern_pkg;

	// Search or locked state of one pattern checker.
	typedef enum logic {SEARCH, LOCKED} lock_state_t;

	// APB request from the master.
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	// Line side strobes and bits from the framer, all on pclk.
	typedef struct packed {
		logic bit_en;
		logic frame_start;
		logic e1_mode;
		logic sys_data;
		logic rx_data;
		logic bipolar_violation;
	} line_in_t;

endpackage : pattern_pkg

// ===== test/line_partner.sv
// Far-end line model: bit and frame timing, highway data and a one-frame loopback.
`timescale 1ns/10ps
`default_nettype none

module line_partner
	import pattern_pkg::*;
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Controls from the bench.
	input wire logic e1_sel,
	input wire logic rx_invert,
	input wire logic bpv_req,
	// Line.
	input wire logic tx_line,
	output var line_in_t line_in
);
	// ------------------------------
	// Timing and loopback
	// ------------------------------
	logic [1:0] div_ff;
	logic [8:0] pos_ff;
	logic [255:0] delay_ff;
	logic [8:0] last_pos;

	assign last_pos = e1_sel ? 9'h0FF : 9'h0C0;

	// One line bit every four clocks; the position wraps at the frame length.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= 2'h0;
			pos_ff <= 9'h000;
		end else begin
			div_ff <= div_ff + 2'h1;
			if (line_in.bit_en) begin
				pos_ff <= (pos_ff >= last_pos) ? 9'h000 : pos_ff + 9'h001;
			end
		end
	end

	// The loop is a whole frame long so that the receive frame lines up with the shared frame strobe.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			delay_ff <= '0;
		end else if (line_in.bit_en) begin
			delay_ff <= {delay_ff[254:0], tx_line};
		end
	end

	// Highway data changes often, so a pattern that fails to replace it shows at once.
	always_comb begin
		line_in.bit_en = (div_ff == 2'h3);
		line_in.frame_start = (div_ff == 2'h3) && (pos_ff == 9'h000);
		line_in.e1_mode = e1_sel;
		line_in.sys_data = pos_ff[0] ^ pos_ff[2];
		line_in.rx_data = (e1_sel ? delay_ff[254] : delay_ff[191]) ^ rx_invert;
		line_in.bipolar_violation = bpv_req && (div_ff == 2'h1);
	end
endmodule : line_partner

`default_nettype wire

// ===== test/line_test_pattern_gen_check_tb.sv
// Self-checking bench for the line test pattern block.
`timescale 1ns/10ps
`default_nettype none
`include "pattern_map.svh"

module line_test_pattern_gen_check_tb
	import pattern_pkg::*;
;
	// ------------------------------
	// Harness
	// ------------------------------
	logic pclk;
	logic presetn;
	apb_req_t req;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	line_in_t li;
	logic tx_line;
	logic e1_sel;
	logic rx_invert;
	logic bpv_req;
	logic [31:0] rd;
	logic err;
	int fail_count;
	int total_checks;

	line_test_pattern_gen_check DUT (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .line_in(li), .tx_line(tx_line));
	line_partner far_end (.pclk(pclk), .presetn(presetn), .e1_sel(e1_sel), .rx_invert(rx_invert),
		.bpv_req(bpv_req), .tx_line(tx_line), .line_in(li));

	// Bus clock of 40 ns.
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// ------------------------------
	// Shared tasks
	// ------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task automatic check1(input logic got, input logic exp, input string what);
		check({31'h0000_0000, got}, {31'h0000_0000, exp}, what);
	endtask : check1

	// One APB transfer; the request stands until pready is seen high.
	task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
		@(posedge pclk);
		req.penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		req <= '0;
	endtask : xfer

	task automatic wr(input logic [11:0] addr, input logic [7:0] d);
		xfer(1'b1, addr, {24'h00_0000, d});
	endtask : wr

	task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp, input string what);
		xfer(1'b0, addr, 32'h0000_0000);
		check(rd, exp, what);
	endtask : rd_chk

	task automatic bits(input int n);
		repeat (n) @(posedge pclk iff li.bit_en);
	endtask : bits

	// Polls status until a bit reaches the wanted level; the poll count bounds the wait.
	task automatic stat_wait(input int idx, input logic want, input string what);
		int n;
		n = 0;
		do begin
			xfer(1'b0, `OFF_RX_STATUS, 32'h0000_0000);
			n++;
		end while (rd[idx] !== want && n < 4000);
		check1(rd[idx], want, what);
	endtask : stat_wait

	// Follows one frame from its first overhead bit and returns the first payload octet.
	task automatic grab(input logic framed, output logic [7:0] oct);
		logic exp;
		@(posedge pclk iff li.frame_start);
		for (int i = 0; i < (li.e1_mode ? 8 : 1); i++) begin
			if (i > 0) @(posedge pclk iff li.bit_en);
			exp = li.sys_data;
			#1;
			if (framed) check1(tx_line, exp, "overhead bit");
		end
		for (int i = 0; i < 8; i++) begin
			@(posedge pclk iff li.bit_en);
			#1;
			oct = {oct[6:0], tx_line};
		end
	endtask : grab

	// Inverts n received bits well inside one frame.
	task automatic burst(input int n);
		@(posedge pclk iff li.frame_start);
		bits(16);
		rx_invert <= 1'b1;
		bits(n);
		rx_invert <= 1'b0;
	endtask : burst

	// Three violation pulses, one per line bit.
	task automatic bpv3();
		@(posedge pclk);
		bpv_req <= 1'b1;
		repeat (12) @(posedge pclk);
		bpv_req <= 1'b0;
	endtask : bpv3

	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic t_regs();
		rd_chk(`OFF_TX_BASIC, 32'h0000_0000, "basic reset");
		rd_chk(`OFF_TX_SELECT, 32'h0000_0000, "select reset");
		rd_chk(`OFF_RX_SELECT, 32'h0000_0000, "detector reset");
		rd_chk(`OFF_IDLE_CODE, {24'h00_0000, `IDLE_RESET}, "idle reset");
		rd_chk(`OFF_RX_STATUS, 32'h0000_0000, "status reset");
		wr(`OFF_IDLE_CODE, 8'hA5);
		rd_chk(`OFF_IDLE_CODE, 32'h0000_00A5, "idle readback");
		xfer(1'b0, 12'h01C, 32'h0000_0000);
		check1(err, 1'b1, "unmapped refused");
		xfer(1'b1, `OFF_RX_STATUS, 32'h0000_00FF);
		check1(err, 1'b1, "status write refused");
		rd_chk(`OFF_RX_STATUS, 32'h0000_0000, "status unchanged");
		$display("register test done");
	endtask : t_regs

	task automatic t_ones();
		wr(`OFF_TX_BASIC, 8'h01);
		bits(2);
		repeat (24) begin
			bits(1);
			#1;
			check1(tx_line, 1'b1, "all ones");
		end
		$display("all ones test done");
	endtask : t_ones

	task automatic t_alt();
		logic prev;
		wr(`OFF_TX_BASIC, 8'h02);
		bits(2);
		#1;
		prev = tx_line;
		repeat (24) begin
			bits(1);
			#1;
			check1(tx_line, ~prev, "alternating");
			prev = tx_line;
		end
		$display("alternating test done");
	endtask : t_alt

	task automatic t_idle();
		logic [7:0] oct;
		wr(`OFF_TX_BASIC, 8'h40);
		for (int m = 0; m < 2; m++) begin
			@(posedge pclk);
			e1_sel <= m[0];
			grab(1'b1, oct);
			grab(1'b1, oct);
			check({24'h00_0000, oct}, 32'h0000_00A5, "idle slot");
		end
		$display("idle code test done");
	endtask : t_idle

	task automatic t_quasi_random_signal();
		logic [7:0] oct;
		@(posedge pclk);
		e1_sel <= 1'b0;
		wr(`OFF_TX_BASIC, 8'h08);
		xfer(1'b0, `OFF_RX_STATUS, 32'h0000_0000);
		check1(rd[`ST_QUASI_RANDOM_SIGNAL_LOCK], 1'b0, "no early lock");
		grab(1'b1, oct);
		stat_wait(`ST_QUASI_RANDOM_SIGNAL_LOCK, 1'b1, "quasi random lock");
		$display("quasi random test done");
	endtask : t_quasi_random_signal

	task automatic t_p15();
		logic [7:0] oct;
		@(posedge pclk);
		e1_sel <= 1'b1;
		wr(`OFF_TX_BASIC, 8'h04);
		grab(1'b1, oct);
		stat_wait(`ST_P15_LOCK, 1'b1, "p15 lock");
		burst(20);
		xfer(1'b0, `OFF_RX_STATUS, 32'h0000_0000);
		check1(rd[`ST_P15_LOCK], 1'b1, "lock holds");
		burst(60);
		xfer(1'b0, `OFF_RX_STATUS, 32'h0000_0000);
		check1(rd[`ST_P15_LOCK], 1'b0, "lock lost");
		$display("p15 monitor test done");
	endtask : t_p15

	// Every select code, framed and unframed in turn, looped back into the detector.
	task automatic t_select();
		logic [7:0] oct;
		logic [3:0] code;
		@(posedge pclk);
		e1_sel <= 1'b0;
		wr(`OFF_TX_BASIC, 8'h00);
		for (int c = 0; c <= 12; c++) begin
			code = c[3:0];
			wr(`OFF_RX_SELECT, {code, code[0], 3'b000});
			wr(`OFF_TX_SELECT, {code, code[0], 3'b000});
			wr(`OFF_RX_SELECT, {code, code[0], 3'b100});
			if (code[0]) grab(1'b1, oct);
			stat_wait(`ST_DET_LOCK, 1'b1, "detector lock");
		end
		$display("select pattern test done");
	endtask : t_select

	task automatic t_errs();
		wr(`OFF_RX_SELECT, 8'h00);
		wr(`OFF_TX_SELECT, 8'h00);
		wr(`OFF_RX_SELECT, 8'h04);
		stat_wait(`ST_DET_LOCK, 1'b1, "ones lock");
		wr(`OFF_VIOL_LO, 8'h00);
		bpv3();
		xfer(1'b0, `OFF_RX_STATUS, 32'h0000_0000);
		wr(`OFF_TX_SELECT, 8'h02);
		bits(300);
		xfer(1'b0, `OFF_RX_STATUS, 32'h0000_0000);
		check1(rd[`ST_DET_ERR], 1'b1, "error flag");
		check1(rd[`ST_DET_LOCK], 1'b1, "lock kept");
		rd_chk(`OFF_VIOL_LO, 32'h0000_0001, "one error");
		rd_chk(`OFF_VIOL_HI, 32'h0000_0000, "error high");
		wr(`OFF_RX_SELECT, 8'h00);
		wr(`OFF_VIOL_LO, 8'h00);
		bpv3();
		rd_chk(`OFF_VIOL_LO, 32'h0000_0003, "violations");
		$display("error count test done");
	endtask : t_errs

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : test_done

	// Main sequence after six cycles of reset.
	initial begin
		fail_count = 0;
		total_checks = 0;
		req = '0;
		presetn = 1'b0;
		e1_sel = 1'b0;
		rx_invert = 1'b0;
		bpv_req = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_ones();
		t_alt();
		t_idle();
		t_quasi_random_signal();
		t_p15();
		t_select();
		t_errs();
		test_done();
	end

	// Watchdog at about twice the expected run length, at 90,000 clocks.
	initial begin
		#3_600_000;
		fail_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		test_done();
	end
endmodule : line_test_pattern_gen_check_tb

`default_nettype wire
